// ### include/cfg_one_pkg.sv
// constants and types for the first extended configuration register block
// ==========================================================================
// Overview of operation
// RULE1 - controller enables the locked loop before treating memory as ready
// RULE2 - after disabling the loop, controller re-enables it before normal use
// RULE3 - self refresh entry stops the loop; exit re-enables and resets it
// RULE4 - no read for 200 clocks after loop enable and reset
// RULE5 - extra read strobe select defaults to zero, function disabled
// RULE6 - calibration adjust write keeps previously programmed added latency
// RULE7 - after calibration default, controller exits with calibration bits 000
// RULE8 - output buffer disable turns off data outputs and both strobe pairs; code gates only outputs_on, not compl_strobe_on or extra_read_strobe
// RULE9 - 50 ohm termination optional on slowest grade, supported on faster ones
// RULE10 - bank bits 01 address this register; bit zero low enables loop
// RULE11 - address bit zero low enables loop, high disables it
// RULE12 - bits 9..7 pick calibration: exit, drive high, drive low, adjust, default
// RULE13 - complement strobes active and terminated only while bit 10 is zero
// RULE14 - termination bits 6,2: off, 75, 150, 50 ohm
// RULE15 - bits 5..3 give added latency 0..6; code 111 reserved
package cfg_one_pkg;
  // ========================================================================
  // field positions
  localparam int ADDR_W = 13;
  localparam int LOOP_OFF_BIT = 0;
  localparam int DRIVE_HALF_BIT = 1;
  localparam int TERM_LO_BIT = 2;
  localparam int LAT_LO_BIT = 3;
  localparam int LAT_HI_BIT = 5;
  localparam int TERM_HI_BIT = 6;
  localparam int CAL_LO_BIT = 7;
  localparam int CAL_HI_BIT = 9;
  localparam int STROBE_OFF_BIT = 10;
  localparam int EXTRA_STROBE_BIT = 11;
  localparam int OUT_OFF_BIT = 12;
  localparam logic [1:0] BANK_SEL = 2'h1;
  // ========================================================================
  // reset values and counts
  localparam logic [12:0] CFG_RESET = 13'h0001;
  localparam int CLK_MHZ = 10;
  localparam int RELOCK_CYCLES = 200;
  localparam logic [2:0] LAT_RESERVED = 3'h7;
  // ========================================================================
  // encodings
  typedef enum logic [2:0] {
    CAL_EXIT = 3'h0,
    CAL_DRIVE_HIGH = 3'h1,
    CAL_DRIVE_LOW = 3'h2,
    CAL_ADJUST = 3'h4,
    CAL_DEFAULT = 3'h7
  } cal_mode_type;
  typedef enum logic [1:0] {
    TERM_OFF = 2'h0,
    TERM_75 = 2'h1,
    TERM_150 = 2'h2,
    TERM_50 = 2'h3
  } term_type;
  typedef enum logic [1:0] {
    LOOP_STOPPED = 2'h0,
    LOOP_LOCKING = 2'h1,
    LOOP_LOCKED = 2'h3
  } loop_state_type;
endpackage

// ### include/relock_if.sv
// carrier between the register block and the relock timer
interface relock_if;
  logic start;
  logic stop;
  logic locked;
  modport ctrl (output start, output stop, input locked);
  modport timer (input start, input stop, output locked);
endinterface

// ### hw/relock_timer.sv
// delay-locked-loop relock timer
module relock_timer
  import cfg_one_pkg::*;
#(
  parameter int CYCLES = RELOCK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  relock_if.timer lk
);
  import cfg_one_pkg::*;

  // counter width follows the lock time so a longer lock time cannot wrap it
  localparam int CNT_W = $clog2(CYCLES);
  loop_state_type state;
  loop_state_type next_state;
  logic [CNT_W-1:0] count;
  wire logic count_done = (count == CNT_W'(CYCLES - 1));

  // lock only after a full count; stop overrides a restart
  always_comb begin
    next_state = state;
    unique case (state)
      LOOP_STOPPED: if (lk.start) next_state = LOOP_LOCKING;
      LOOP_LOCKING: if (count_done) next_state = LOOP_LOCKED;
      LOOP_LOCKED: if (lk.start) next_state = LOOP_LOCKING;
      default: next_state = LOOP_STOPPED;
    endcase
    if (lk.stop) next_state = LOOP_STOPPED;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= LOOP_STOPPED;
      count <= '0;
    end else begin
      state <= next_state;
      count <= (next_state == LOOP_LOCKING && state == LOOP_LOCKING) ? count + CNT_W'(1) : '0; // RULE4
    end
  end

  assign lk.locked = (state == LOOP_LOCKED);

  a_lock_after_count: assert property (@(posedge core_clk) disable iff (reset) // RULE4
    lk.start && !lk.stop |=> !lk.locked [*8])
    else $error("locked too early after restart");
endmodule

// ### hw/ext_config_one.sv
// first extended configuration register with loop enable and relock tracking
module ext_config_one
  import cfg_one_pkg::*;
#(
  parameter bit FAST_GRADE = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // configuration command from the controller
  input wire logic cfg_write,
  input wire logic [1:0] bank_sel,
  input wire logic [cfg_one_pkg::ADDR_W-1:0] addr,
  // self refresh state
  input wire logic self_refresh_enter,
  input wire logic self_refresh_exit,
  // decoded fields
  output logic loop_enabled,
  output logic half_drive,
  output cfg_one_pkg::term_type term_sel,
  output logic [2:0] added_latency,
  output cfg_one_pkg::cal_mode_type driver_calibration,
  output logic compl_strobe_on,
  output logic extra_read_strobe,
  output logic outputs_on,
  // readiness
  output logic read_allowed,
  output logic in_self_refresh
);
  import cfg_one_pkg::*;

  // ==========================================================================
  // register write decode
  logic [ADDR_W-1:0] extended_config_one;
  logic [ADDR_W-1:0] next_cfg;
  logic sr;
  logic prev_loop_on;
  wire logic hit = cfg_write && (bank_sel == BANK_SEL); // RULE10
  wire logic [2:0] new_cal = addr[CAL_HI_BIT:CAL_LO_BIT];
  wire logic cal_legal = new_cal inside {CAL_EXIT, CAL_DRIVE_HIGH, CAL_DRIVE_LOW, CAL_ADJUST, CAL_DEFAULT}; // RULE12
  wire logic [1:0] new_term = {addr[TERM_HI_BIT], addr[TERM_LO_BIT]};
  // slow grade drops 50 ohm back to off since the setting may not exist
  wire logic term_ok = FAST_GRADE || (new_term != TERM_50); // RULE9
  wire logic lat_ok = addr[LAT_HI_BIT:LAT_LO_BIT] != LAT_RESERVED; // RULE15
  wire logic [2:0] new_lat = addr[LAT_HI_BIT:LAT_LO_BIT];

  // illegal codes fall back: reserved latency keeps old, adjust keeps old latency
  always_comb begin
    next_cfg = addr;
    if (!term_ok) begin
      next_cfg[TERM_HI_BIT] = 1'b0;
      next_cfg[TERM_LO_BIT] = 1'b0;
    end
    if (!lat_ok || new_cal == CAL_ADJUST) // RULE6
      next_cfg[LAT_HI_BIT:LAT_LO_BIT] = extended_config_one[LAT_HI_BIT:LAT_LO_BIT]; // RULE15
    if (!cal_legal)
      next_cfg[CAL_HI_BIT:CAL_LO_BIT] = extended_config_one[CAL_HI_BIT:CAL_LO_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      extended_config_one <= CFG_RESET; // RULE5
      sr <= 1'b0;
      prev_loop_on <= 1'b0;
    end else begin
      if (hit) extended_config_one <= next_cfg;
      if (self_refresh_enter) sr <= 1'b1;
      else if (self_refresh_exit) sr <= 1'b0;
      prev_loop_on <= loop_enabled;
    end
  end

  // ==========================================================================
  // field outputs
  wire logic cfg_loop_on = !extended_config_one[LOOP_OFF_BIT]; // RULE11
  assign loop_enabled = cfg_loop_on && !sr; // RULE3
  assign half_drive = extended_config_one[DRIVE_HALF_BIT];
  assign term_sel = sr ? TERM_OFF : term_type'({extended_config_one[TERM_HI_BIT], extended_config_one[TERM_LO_BIT]}); // RULE14
  assign added_latency = extended_config_one[LAT_HI_BIT:LAT_LO_BIT]; // RULE15
  assign driver_calibration = cal_mode_type'(extended_config_one[CAL_HI_BIT:CAL_LO_BIT]); // RULE12
  assign compl_strobe_on = !extended_config_one[STROBE_OFF_BIT]; // RULE13
  assign extra_read_strobe = extended_config_one[EXTRA_STROBE_BIT]; // RULE5
  // drivers off clears outputs_on only, not compl_strobe_on or extra_read_strobe; used for current measurement
  assign outputs_on = !extended_config_one[OUT_OFF_BIT]; // RULE8
  assign in_self_refresh = sr;

  // ==========================================================================
  // relock tracking: any rise of the effective enable restarts the count
  relock_if lk ();
  assign lk.start = loop_enabled && !prev_loop_on; // RULE3
  assign lk.stop = !loop_enabled; // RULE2
  assign read_allowed = lk.locked && loop_enabled; // RULE1 RULE4

  relock_timer #(.CYCLES(RELOCK_CYCLES)) timer_u (
    .core_clk(core_clk),
    .reset(reset),
    .lk(lk)
  );

  // ==========================================================================
  // relock age: cycles of unbroken effective enable, saturating just past the lock time
  // kept apart from the timer so the hold-off checks do not lean on its own counter
  localparam int AGE_W = $clog2(RELOCK_CYCLES + 2);
  localparam logic [AGE_W-1:0] AGE_MAX = AGE_W'(RELOCK_CYCLES + 1);
  localparam logic [AGE_W-1:0] AGE_LOCK = AGE_W'(RELOCK_CYCLES);
  logic [AGE_W-1:0] relock_age;

  // any drop of the enable, self refresh included, starts the age over
  always_ff @(posedge core_clk) begin
    if (reset || !loop_enabled) begin
      relock_age <= '0;
    end else if (relock_age != AGE_MAX) begin
      relock_age <= relock_age + AGE_W'(1);
    end
  end

  // ==========================================================================
  // checks: register decode one cycle after a write, plus standing field and reset checks
  // writes to other banks must leave every field alone
  a_decode_bank_hit: assert property (@(posedge core_clk) disable iff (reset) // RULE10
    hit && addr[LOOP_OFF_BIT] |=> !cfg_loop_on)
    else $error("disable bit not stored");
  a_other_bank: assert property (@(posedge core_clk) disable iff (reset) // RULE10
    cfg_write && bank_sel != BANK_SEL |=> $stable(extended_config_one))
    else $error("write to another bank landed here");
  a_loop_bit_polarity: assert property (@(posedge core_clk) disable iff (reset) // RULE11
    hit && !addr[LOOP_OFF_BIT] |=> cfg_loop_on)
    else $error("enable bit not stored");
  a_term_store: assert property (@(posedge core_clk) disable iff (reset) // RULE14
    hit && term_ok && !in_self_refresh && !self_refresh_enter |=> term_sel == $past(new_term))
    else $error("termination code not stored");
  a_slow_drops_50: assert property (@(posedge core_clk) disable iff (reset) // RULE9
    !FAST_GRADE && hit && new_term == TERM_50 |=> term_sel == TERM_OFF)
    else $error("slow grade took 50 ohm");
  a_slow_no_50: assert property (@(posedge core_clk) disable iff (reset) // RULE9
    !FAST_GRADE |-> term_sel != TERM_50)
    else $error("slow grade shows 50 ohm");
  a_latency_reserved: assert property (@(posedge core_clk) disable iff (reset) // RULE15
    added_latency != LAT_RESERVED)
    else $error("reserved latency stored");
  a_lat_store: assert property (@(posedge core_clk) disable iff (reset) // RULE15
    hit && lat_ok && new_cal != CAL_ADJUST |=> added_latency == $past(new_lat))
    else $error("latency not stored");
  a_lat_reserved_keep: assert property (@(posedge core_clk) disable iff (reset) // RULE15
    hit && !lat_ok |=> $stable(added_latency))
    else $error("reserved latency changed field");
  a_adjust_keeps_lat: assert property (@(posedge core_clk) disable iff (reset) // RULE6
    hit && new_cal == CAL_ADJUST |=> $stable(added_latency))
    else $error("adjust changed latency");
  a_cal_decode: assert property (@(posedge core_clk) disable iff (reset) // RULE12
    hit && cal_legal |=> driver_calibration == $past(new_cal))
    else $error("calibration code not stored");
  a_cal_illegal: assert property (@(posedge core_clk) disable iff (reset) // RULE12
    hit && !cal_legal |=> $stable(driver_calibration))
    else $error("illegal calibration code stored");
  a_buffer_off: assert property (@(posedge core_clk) disable iff (reset) // RULE8
    hit && addr[OUT_OFF_BIT] |=> !outputs_on)
    else $error("outputs not disabled");
  a_buffer_on: assert property (@(posedge core_clk) disable iff (reset) // RULE8
    hit && !addr[OUT_OFF_BIT] |=> outputs_on)
    else $error("outputs not enabled");
  a_strobe_off: assert property (@(posedge core_clk) disable iff (reset) // RULE13
    hit && addr[STROBE_OFF_BIT] |=> !compl_strobe_on)
    else $error("complement strobe not off");
  a_strobe_on: assert property (@(posedge core_clk) disable iff (reset) // RULE13
    hit && !addr[STROBE_OFF_BIT] |=> compl_strobe_on)
    else $error("complement strobe not on");
  a_extra_set: assert property (@(posedge core_clk) disable iff (reset) // RULE5
    hit && addr[EXTRA_STROBE_BIT] |=> extra_read_strobe)
    else $error("extra strobe not set");
  a_extra_clear: assert property (@(posedge core_clk) disable iff (reset) // RULE5
    hit && !addr[EXTRA_STROBE_BIT] |=> !extra_read_strobe)
    else $error("extra strobe not cleared");
  a_reset_extra: assert property (@(posedge core_clk) // RULE5
    $fell(reset) |-> !extra_read_strobe)
    else $error("extra strobe set after reset");
  // reset is watched here, so no disable on this one
  a_reset_state: assert property (@(posedge core_clk) // RULE5
    reset |=> !loop_enabled && !read_allowed && outputs_on && compl_strobe_on && !extra_read_strobe)
    else $error("wrong state after reset");

  // ==========================================================================
  // checks: self refresh; entry wins when both pulses meet
  a_sr_stops_loop: assert property (@(posedge core_clk) disable iff (reset) // RULE3
    self_refresh_enter |=> !loop_enabled && !read_allowed)
    else $error("loop alive in self refresh");
  a_sr_set_wins: assert property (@(posedge core_clk) disable iff (reset) // RULE3
    self_refresh_enter |=> in_self_refresh)
    else $error("self refresh flag not set");
  a_sr_clear: assert property (@(posedge core_clk) disable iff (reset) // RULE3
    self_refresh_exit && !self_refresh_enter |=> !in_self_refresh)
    else $error("self refresh flag not cleared");
  a_sr_exit_restart: assert property (@(posedge core_clk) disable iff (reset) // RULE3
    in_self_refresh && self_refresh_exit && !self_refresh_enter && !hit && cfg_loop_on |=> loop_enabled && lk.start)
    else $error("loop not restarted on self refresh exit");

  // ==========================================================================
  // checks: relock hold-off; the early and release checks are judged against the independent age counter
  a_read_holdoff: assert property (@(posedge core_clk) disable iff (reset) // RULE4
    lk.start |-> !read_allowed [*8])
    else $error("reads allowed during relock");
  a_loop_restart: assert property (@(posedge core_clk) disable iff (reset) // RULE4
    hit && !addr[LOOP_OFF_BIT] && !cfg_loop_on && !in_self_refresh && !self_refresh_enter |=> lk.start)
    else $error("enable write did not restart relock");
  a_disable_blocks_read: assert property (@(posedge core_clk) disable iff (reset) // RULE2
    hit && addr[LOOP_OFF_BIT] |=> !read_allowed)
    else $error("reads allowed with loop off");
  a_read_early: assert property (@(posedge core_clk) disable iff (reset) // RULE4
    relock_age < AGE_LOCK |-> !read_allowed)
    else $error("reads allowed before lock time");
  a_read_release: assert property (@(posedge core_clk) disable iff (reset) // RULE4
    loop_enabled && relock_age == AGE_MAX |-> read_allowed)
    else $error("reads not released after relock");

  // ==========================================================================
  // covers for the main scenarios
  c_relock_done: cover property (@(posedge core_clk) disable iff (reset)
    $rose(read_allowed));
  c_sr_cycle: cover property (@(posedge core_clk) disable iff (reset)
    self_refresh_exit ##1 lk.start);
  c_cal_default: cover property (@(posedge core_clk) disable iff (reset)
    driver_calibration == CAL_DEFAULT);
  c_adjust_write: cover property (@(posedge core_clk) disable iff (reset)
    hit && new_cal == CAL_ADJUST);
  c_buffer_off: cover property (@(posedge core_clk) disable iff (reset)
    !outputs_on);
endmodule

// ### verif/ctl_model.sv
// controller model issuing configuration writes
module ctl_model (
  // clock
  input wire logic core_clk,
  // configuration command
  output logic cfg_write,
  output logic [1:0] bank_sel,
  output logic [12:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle command at time zero
  initial begin
    cfg_write = 1'b0;
    bank_sel = 2'h0;
    addr = 13'h0000;
  end
  // one write held across its edge, then lines inverted so nothing stale looks valid
  task automatic put(input logic [1:0] b, input logic [12:0] v);
    @(posedge core_clk) #1;
    cfg_write = 1'b1;
    bank_sel = b;
    addr = v;
    @(posedge core_clk) #1;
    cfg_write = 1'b0;
    bank_sel = ~b;
    addr = ~v;
  endtask
  // no read until the loop has had its lock time
  task automatic wait_lock();
    repeat (200) @(posedge core_clk);
  endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the first extended configuration register
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cfg_one_pkg::*;
  logic core_clk, reset, sr_in, sr_out, cfg_write;
  logic [1:0] bank_sel;
  logic [12:0] addr;
  logic loop_en, half, cstrobe, xstrobe, outs_on, rd_ok, in_sr;
  term_type term;
  term_type term_slow;
  logic [2:0] lat;
  cal_mode_type cal;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  // ==========================================================
  // device and controller
  ctl_model ctl (.core_clk(core_clk), .cfg_write(cfg_write), .bank_sel(bank_sel), .addr(addr));
  ext_config_one #(.FAST_GRADE(1'b1)) dut (.core_clk(core_clk), .reset(reset), .cfg_write(cfg_write),
    .bank_sel(bank_sel), .addr(addr), .self_refresh_enter(sr_in), .self_refresh_exit(sr_out),
    .loop_enabled(loop_en), .half_drive(half), .term_sel(term), .added_latency(lat),
    .driver_calibration(cal), .compl_strobe_on(cstrobe), .extra_read_strobe(xstrobe),
    .outputs_on(outs_on), .read_allowed(rd_ok), .in_self_refresh(in_sr));
  // slow grade twin on the same command lines; only its termination is judged
  ext_config_one #(.FAST_GRADE(1'b0)) dut_slow (.core_clk(core_clk), .reset(reset), .cfg_write(cfg_write),
    .bank_sel(bank_sel), .addr(addr), .self_refresh_enter(sr_in), .self_refresh_exit(sr_out),
    .loop_enabled(), .half_drive(), .term_sel(term_slow), .added_latency(),
    .driver_calibration(), .compl_strobe_on(), .extra_read_strobe(),
    .outputs_on(), .read_allowed(), .in_self_refresh());
  // clock and hang guard; the run needs about 470 cycles
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic pulse(input logic enter);
    @(posedge core_clk) #1;
    sr_in = enter;
    sr_out = !enter;
    @(posedge core_clk) #1;
    sr_in = 1'b0;
    sr_out = 1'b0;
  endtask
  // read hold-off: still low at 200 cycles, high a few later
  task automatic relock();
    ctl.wait_lock();
    #1;
    check("read_allowed", rd_ok, 1'b0);
    repeat (10) @(posedge core_clk);
    #1;
    check("read_allowed", rd_ok, 1'b1);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_enable();
    check("outputs_on", outs_on, 1'b1);
    check("compl_strobe_on", cstrobe, 1'b1);
    check("extra_read_strobe", xstrobe, 1'b0);
    check("loop_enabled", loop_en, 1'b0);
    ctl.put(BANK_SEL, 13'h0000);
    check("loop_enabled", loop_en, 1'b1);
    relock();
    $display("enable done");
  endtask
  task automatic t_bank();
    for (int b = 0; b < 4; b++) begin
      if (b != 1) begin
        ctl.put(b[1:0], 13'h1c01);
        check("loop_enabled", loop_en, 1'b1);
      end
    end
    ctl.put(BANK_SEL, 13'h0001);
    check("loop_enabled", loop_en, 1'b0);
    ctl.put(BANK_SEL, 13'h0000);
    check("read_allowed", rd_ok, 1'b0);
    $display("bank done");
  endtask
  task automatic t_fields();
    for (int t = 0; t < 4; t++) begin
      ctl.put(BANK_SEL, {3'h7, 3'h0, t[1], 3'h5, t[0], 2'h2});
      check("term_sel", term, t[1:0]);
      check("term_sel_slow", term_slow, (t == 3) ? 2'h0 : t[1:0]);
      check("added_latency", lat, 3'h5);
      check("half_drive", half, 1'b1);
      check("compl_strobe_on", cstrobe, 1'b0);
      check("extra_read_strobe", xstrobe, 1'b1);
      check("outputs_on", outs_on, 1'b0);
    end
    $display("fields done");
  endtask
  task automatic t_cal();
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h7, 3'h0, 3'h4};
    for (int i = 0; i < 5; i++) begin
      ctl.put(BANK_SEL, {3'h0, codes[i], 7'h18 + 7'(i / 4 * 24)});
      check("driver_calibration", cal, codes[i]);
      check("added_latency", lat, 3'h3);
    end
    ctl.put(BANK_SEL, {3'h0, 3'h3, 7'h38});
    check("driver_calibration", cal, 3'h4);
    check("added_latency", lat, 3'h3);
    $display("calibration done");
  endtask
  task automatic t_sr();
    ctl.put(BANK_SEL, 13'h0044);
    check("term_sel", term, 2'h3);
    pulse(1'b1);
    check("loop_enabled", loop_en, 1'b0);
    check("read_allowed", rd_ok, 1'b0);
    check("in_self_refresh", in_sr, 1'b1);
    check("term_sel", term, 2'h0);
    pulse(1'b0);
    check("loop_enabled", loop_en, 1'b1);
    check("in_self_refresh", in_sr, 1'b0);
    check("term_sel", term, 2'h3);
    relock();
    $display("self refresh done");
  endtask
  // reset for 12 cycles, then the scenarios in order
  initial begin
    reset = 1'b1;
    sr_in = 1'b0;
    sr_out = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_enable();
    t_bank();
    t_fields();
    t_cal();
    t_sr();
    test_done();
  end
endmodule
